// ==== design/address_breakpoint_match.sv ====
// Purpose: Debug address breakpoint registers and trigger.
// Assumes: CPU and debug port share the core clock; debug port never
//          overlaps a CPU debug write in software terms.
// Notes:   Register writes from the debug port win over the CPU.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module address_breakpoint_match #(parameter int ADDR_W = 32)
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	// CPU debug write instruction
	input  wire logic              cpu_wr,
	input  wire logic [4:0]        cpu_sel,
	input  wire logic [31:0]       cpu_wdata,
	// Debug port register and memory commands
	input  wire logic              dbg_req,
	input  wire logic              dbg_wr,
	input  wire logic [4:0]        dbg_sel,
	input  wire logic [31:0]       dbg_wdata,
	output logic      [31:0]       dbg_rdata,
	output logic                   dbg_rvalid,
	input  wire logic              dbg_mem_req,
	input  wire logic [ADDR_W-1:0] dbg_mem_addr,
	output logic      [ADDR_W-1:0] mem_cmd_addr,
	output logic      [1:0]        mem_cmd_class,
	output logic      [2:0]        mem_cmd_mod,
	// Processor local bus
	input  wire logic              bus_valid,
	input  wire logic [ADDR_W-1:0] bus_addr,
	input  wire logic              bus_rd,
	input  wire logic [1:0]        bus_size,
	input  wire logic [1:0]        bus_class,
	input  wire logic [2:0]        bus_mod,
	// Trigger control and result
	input  wire logic              bp_enable,
	input  wire logic [1:0]        addr_case,
	output logic                   addr_trigger,
	output logic      [15:0]       debug_cfg
);
	if (ADDR_W < 2 || ADDR_W > 32)
	begin : g_bad_width
		$error("ADDR_W must lie in 2..32");
	end

	////////////////////////////////////////////////////////////////////////
	typedef struct packed
	{
		logic [15:0]       cfg;
		logic              inhibit;
		logic              trig;
		logic [15:0]       attr;
		logic [ADDR_W-1:0] low;
		logic [ADDR_W-1:0] high;
		logic [31:0]       rdata;
		logic              rvalid;
	} regs_t;

	regs_t             st_r;
	regs_t             st_nxt;
	logic              dbg_write;
	logic              dbg_read;
	logic              cpu_write;
	logic              wr_go;
	logic [4:0]        wr_sel;
	logic [31:0]       wr_data;
	logic [3:0]        bp_state;
	logic [31:0]       config_word;

	cmp_if #(.ADDR_W(ADDR_W)) cif ();

	addr_attr_compare #(.ADDR_W(ADDR_W)) u_cmp
	(
		.clock (clock),
		.rst_n (rst_n),
		.cif   (cif)
	);

	assign cif.low       = st_r.low;
	assign cif.high      = st_r.high;
	assign cif.attr      = st_r.attr;
	assign cif.addr_case = addr_case;
	assign cif.enable    = bp_enable;
	assign cif.bus_valid = bus_valid;
	assign cif.bus_addr  = bus_addr;
	assign cif.bus_rd    = bus_rd;
	assign cif.bus_size  = bus_size;
	assign cif.bus_class = bus_class;
	assign cif.bus_mod   = bus_mod;

	////////////////////////////////////////////////////////////////////////
	// Write arbitration
	assign dbg_write = dbg_req & dbg_wr;
	assign dbg_read  = dbg_req & ~dbg_wr;
	// Debug port holds the bus; CPU writes dropped while inhibited
	assign cpu_write = cpu_wr & ~st_r.inhibit & ~dbg_req;
	assign wr_go     = dbg_write | cpu_write;
	assign wr_sel    = dbg_write ? dbg_sel : cpu_sel;
	assign wr_data   = dbg_write ? dbg_wdata : cpu_wdata;

	// Status nibble tracks bp_enable and the sticky address trigger
	always_comb
	begin
		if (!bp_enable)
			bp_state = abm_pkg::ST_IDLE;
		else if (st_r.trig)
			bp_state = abm_pkg::ST_TRIGGERED;
		else
			bp_state = abm_pkg::ST_WAITING;
	end

	always_comb
	begin
		config_word = '0;
		config_word[abm_pkg::STATUS_LSB +: 4] = bp_state;
		config_word[abm_pkg::TRIG_BIT] = st_r.trig;
		config_word[23:20] = abm_pkg::HW_REVISION;
		config_word[abm_pkg::INHIBIT_BIT] = st_r.inhibit;
		config_word[15:0] = st_r.cfg;
	end

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		if (wr_go)
		begin
			case (wr_sel)
				abm_pkg::SEL_CONFIG:
				begin
					st_nxt.cfg = wr_data[15:0];
					if (dbg_write)
						st_nxt.inhibit = wr_data[abm_pkg::INHIBIT_BIT];
				end
				abm_pkg::SEL_ATTRIBUTE:  st_nxt.attr = wr_data[15:0];
				abm_pkg::SEL_HIGH_BOUND: st_nxt.high = wr_data[ADDR_W-1:0];
				abm_pkg::SEL_LOW_BOUND:  st_nxt.low = wr_data[ADDR_W-1:0];
				default:                 st_nxt.cfg = st_r.cfg;
			endcase
		end
		// Shared with breakpoint use: a memory command destroys the ceiling
		if (dbg_mem_req)
			st_nxt.high = dbg_mem_addr;
		// Only the debug port reads; CPU has no read path
		if (dbg_read)
		begin
			st_nxt.rvalid = 1'b1;
			case (dbg_sel)
				abm_pkg::SEL_CONFIG:     st_nxt.rdata = config_word;
				abm_pkg::SEL_ATTRIBUTE:  st_nxt.rdata = {16'h0000, st_r.attr};
				abm_pkg::SEL_HIGH_BOUND: st_nxt.rdata = 32'(st_r.high);
				abm_pkg::SEL_LOW_BOUND:  st_nxt.rdata = 32'(st_r.low);
				default:                 st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Set wins over the read-clear
		st_nxt.trig = cif.hit | (st_r.trig & ~(dbg_read && dbg_sel == abm_pkg::SEL_CONFIG));
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r        <= '0;
			st_r.cfg    <= abm_pkg::CONFIG_RESET[15:0];
			st_r.inhibit <= abm_pkg::CONFIG_RESET[abm_pkg::INHIBIT_BIT];
			st_r.attr   <= abm_pkg::ATTR_RESET;
			st_r.low    <= abm_pkg::BOUND_RESET[ADDR_W-1:0];
			st_r.high   <= abm_pkg::BOUND_RESET[ADDR_W-1:0];
		end
		else
			st_r <= st_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	assign dbg_rdata     = st_r.rdata;
	assign dbg_rvalid    = st_r.rvalid;
	assign mem_cmd_addr  = st_r.high;
	assign mem_cmd_class = st_r.attr[abm_pkg::CLASS_LSB +: 2];
	assign mem_cmd_mod   = st_r.attr[abm_pkg::MOD_LSB +: 3];
	assign addr_trigger  = cif.hit;
	assign debug_cfg     = st_r.cfg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_xfer;
		bus_valid && bp_enable;
	endsequence

	sequence s_cpu_low_blocked;
		cpu_wr && st_r.inhibit && !dbg_req && !dbg_mem_req && cpu_sel == abm_pkg::SEL_LOW_BOUND;
	endsequence

	property p_cpu_blocked;
		@(posedge clock) disable iff (!rst_n)
		s_cpu_low_blocked |=> st_r.low == $past(st_r.low);
	endproperty
	a_cpu_blocked: assert property (p_cpu_blocked) else $error("CPU write passed inhibit");

	property p_cpu_no_inhibit;
		@(posedge clock) disable iff (!rst_n)
		!dbg_req |=> st_r.inhibit == $past(st_r.inhibit);
	endproperty
	a_cpu_no_inhibit: assert property (p_cpu_no_inhibit) else $error("Inhibit changed without debug port");

	property p_mem_high;
		@(posedge clock) disable iff (!rst_n)
		dbg_mem_req |=> mem_cmd_addr == $past(dbg_mem_addr);
	endproperty
	a_mem_high: assert property (p_mem_high) else $error("Memory command address not in high bound");

	property p_mem_class;
		@(posedge clock) disable iff (!rst_n)
		dbg_write && dbg_sel == abm_pkg::SEL_ATTRIBUTE
			|=> mem_cmd_class == $past(dbg_wdata[4:3]) && mem_cmd_mod == $past(dbg_wdata[2:0]);
	endproperty
	a_mem_class: assert property (p_mem_class) else $error("Memory command attributes wrong");

	property p_config_read;
		@(posedge clock) disable iff (!rst_n)
		dbg_read && dbg_sel == abm_pkg::SEL_CONFIG
			|=> dbg_rvalid && dbg_rdata[15:0] == debug_cfg && dbg_rdata[abm_pkg::INHIBIT_BIT] == st_r.inhibit
				&& dbg_rdata[abm_pkg::TRIG_BIT] == $past(st_r.trig) && dbg_rdata[31:28] == $past(bp_state);
	endproperty
	a_config_read: assert property (p_config_read) else $error("Config read data wrong");

	property p_equal_miss;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and (addr_case == abm_pkg::CASE_EQUAL && bus_addr != st_r.low) |=> !addr_trigger;
	endproperty
	a_equal_miss: assert property (p_equal_miss) else $error("Equal case fired off address");

	property p_inside_miss;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and (addr_case == abm_pkg::CASE_INSIDE && (bus_addr < st_r.low || bus_addr > st_r.high))
			|=> !addr_trigger;
	endproperty
	a_inside_miss: assert property (p_inside_miss) else $error("Inside case fired out of range");

	property p_dir_miss;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and (!st_r.attr[abm_pkg::DIR_MASK_BIT] && bus_rd != st_r.attr[abm_pkg::DIR_BIT]) |=> !addr_trigger;
	endproperty
	a_dir_miss: assert property (p_dir_miss) else $error("Direction mismatch fired");

	property p_width_miss;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and (|(~st_r.attr[14:13] & (bus_size ^ st_r.attr[6:5]))) |=> !addr_trigger;
	endproperty
	a_width_miss: assert property (p_width_miss) else $error("Width mismatch fired");

	property p_class_mod_miss;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and (|(~st_r.attr[12:8] & ({bus_class, bus_mod} ^ st_r.attr[4:0]))) |=> !addr_trigger;
	endproperty
	a_class_mod_miss: assert property (p_class_mod_miss) else $error("Class or modifier mismatch fired");

	property p_trig_cause;
		@(posedge clock) disable iff (!rst_n)
		addr_trigger |-> $past(bus_valid && bp_enable) ##1 st_r.trig;
	endproperty
	a_trig_cause: assert property (p_trig_cause) else $error("Trigger without transfer or status");

	sequence s_config_read;
		dbg_read && dbg_sel == abm_pkg::SEL_CONFIG;
	endsequence

	sequence s_in_range;
		bus_addr >= st_r.low && bus_addr <= st_r.high;
	endsequence

	// A read that clears status must not swallow a hit of the same cycle
	property p_set_wins;
		@(posedge clock) disable iff (!rst_n)
		s_config_read and (cif.hit) |=> st_r.trig;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Status read lost a same-cycle trigger");

	property p_read_answer;
		@(posedge clock) disable iff (!rst_n)
		dbg_read |=> dbg_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("Read got no answer");

	property p_rvalid_pulse;
		@(posedge clock) disable iff (!rst_n)
		!dbg_read |=> !dbg_rvalid;
	endproperty
	a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("Read answer without read");

	property p_unmapped_read;
		@(posedge clock) disable iff (!rst_n)
		dbg_read && dbg_sel != abm_pkg::SEL_CONFIG && dbg_sel != abm_pkg::SEL_ATTRIBUTE
			&& dbg_sel != abm_pkg::SEL_HIGH_BOUND && dbg_sel != abm_pkg::SEL_LOW_BOUND |=> dbg_rdata == 32'h0000_0000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

	property p_cpu_lands;
		@(posedge clock) disable iff (!rst_n)
		cpu_wr && !st_r.inhibit && !dbg_req && cpu_sel == abm_pkg::SEL_LOW_BOUND
			|=> st_r.low == $past(cpu_wdata[ADDR_W-1:0]);
	endproperty
	a_cpu_lands: assert property (p_cpu_lands) else $error("Allowed CPU write lost");

	property p_outside_miss;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and s_in_range and (addr_case == abm_pkg::CASE_OUTSIDE) |=> !addr_trigger;
	endproperty
	a_outside_miss: assert property (p_outside_miss) else $error("Outside case fired in range");

	property p_inside_hit;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and s_in_range and (addr_case == abm_pkg::CASE_INSIDE && &st_r.attr[15:8]) |=> addr_trigger;
	endproperty
	a_inside_hit: assert property (p_inside_hit) else $error("Inside case missed in range");

	property p_case_never;
		@(posedge clock) disable iff (!rst_n)
		s_xfer and (addr_case == 2'h3) |=> !addr_trigger;
	endproperty
	a_case_never: assert property (p_case_never) else $error("Unused case select fired");

	property p_disabled;
		@(posedge clock) disable iff (!rst_n)
		!bp_enable |=> !addr_trigger;
	endproperty
	a_disabled: assert property (p_disabled) else $error("Trigger while disabled");
endmodule

// ==== design/abm_pkg.sv ====
// Purpose: Shared constants of the address breakpoint comparator.
// Assumes: 32-bit debug register data, 5-bit register select.
// Notes:   Register numbers are the debug register select codes.
package abm_pkg;
	// Register select codes
	localparam logic [4:0]  SEL_CONFIG     = 5'h00;
	localparam logic [4:0]  SEL_ATTRIBUTE  = 5'h06;
	localparam logic [4:0]  SEL_HIGH_BOUND = 5'h0C;
	localparam logic [4:0]  SEL_LOW_BOUND  = 5'h0D;
	// Reset values
	localparam logic [31:0] CONFIG_RESET   = 32'h0001_0000;
	localparam logic [15:0] ATTR_RESET     = 16'h0005;
	localparam logic [31:0] BOUND_RESET    = 32'h0000_0000;
	// Attribute register fields
	localparam int          DIR_MASK_BIT   = 15;
	localparam int          WIDTH_MASK_LSB = 13;
	localparam int          CLASS_MASK_LSB = 11;
	localparam int          MOD_MASK_LSB   = 8;
	localparam int          DIR_BIT        = 7;
	localparam int          WIDTH_LSB      = 5;
	localparam int          CLASS_LSB      = 3;
	localparam int          MOD_LSB        = 0;
	localparam int          MASK_LSB       = 8;
	// Config/status fields
	localparam int          INHIBIT_BIT    = 16;
	localparam int          TRIG_BIT       = 26;
	localparam int          STATUS_LSB     = 28;
	localparam logic [3:0]  HW_REVISION    = 4'h0;
	localparam logic [3:0]  ST_IDLE        = 4'h0;
	localparam logic [3:0]  ST_WAITING     = 4'h1;
	localparam logic [3:0]  ST_TRIGGERED   = 4'h2;
	// Address case select
	localparam logic [1:0]  CASE_EQUAL     = 2'h0;
	localparam logic [1:0]  CASE_INSIDE    = 2'h1;
	localparam logic [1:0]  CASE_OUTSIDE   = 2'h2;
	// Width encodings
	localparam logic [1:0]  WIDTH_LONG     = 2'h0;
	localparam logic [1:0]  WIDTH_BYTE     = 2'h1;
	localparam logic [1:0]  WIDTH_WORD     = 2'h2;
	// Access class encodings
	localparam logic [1:0]  CLASS_NORMAL   = 2'h0;
	localparam logic [1:0]  CLASS_EXTERNAL = 2'h1;
	localparam logic [1:0]  CLASS_EMULATOR = 2'h2;
	localparam logic [1:0]  CLASS_ACK      = 2'h3;
	// Modifier encodings
	localparam logic [2:0]  MOD_LINE_PUSH  = 3'h0;
	localparam logic [2:0]  MOD_USER_DATA  = 3'h1;
	localparam logic [2:0]  MOD_USER_CODE  = 3'h2;
	localparam logic [2:0]  MOD_SUP_DATA   = 3'h5;
	localparam logic [2:0]  MOD_SUP_CODE   = 3'h6;
	localparam logic [2:0]  MOD_CPU_SPACE  = 3'h0;
endpackage

// ==== design/cmp_if.sv ====
// Purpose: Carries bound, attribute and bus fields to the comparator.
// Assumes: Single clock domain.
// Notes:   hit is registered inside the comparator.
`timescale 1ns/1ps
interface cmp_if #(parameter int ADDR_W = 32);
	logic [ADDR_W-1:0] low;
	logic [ADDR_W-1:0] high;
	logic [15:0]       attr;
	logic [1:0]        addr_case;
	logic              enable;
	logic              bus_valid;
	logic [ADDR_W-1:0] bus_addr;
	logic              bus_rd;
	logic [1:0]        bus_size;
	logic [1:0]        bus_class;
	logic [2:0]        bus_mod;
	logic              hit;
	modport regs (output low, high, attr, addr_case, enable, bus_valid, bus_addr,
		bus_rd, bus_size, bus_class, bus_mod, input hit);
	modport cmp (input low, high, attr, addr_case, enable, bus_valid, bus_addr,
		bus_rd, bus_size, bus_class, bus_mod, output hit);
endinterface

// ==== design/addr_attr_compare.sv ====
// Purpose: Address case and masked attribute comparison per transfer.
// Assumes: One bus transfer per valid cycle.
// Notes:   Hit shows one cycle after the transfer.
`timescale 1ns/1ps
module addr_attr_compare #(parameter int ADDR_W = 32)
(
	input  wire logic clock,
	input  wire logic rst_n,
	cmp_if.cmp        cif
);
	if (ADDR_W < 2 || ADDR_W > 32)
	begin : g_bad_width
		$error("ADDR_W must lie in 2..32");
	end

	typedef struct packed
	{
		logic hit;
	} cmp_state_t;

	cmp_state_t      st_r;
	cmp_state_t      st_nxt;
	logic [7:0]      bus_attr;
	logic [7:0]      bit_ok;
	logic            addr_ok;

	assign bus_attr = {cif.bus_rd, cif.bus_size, cif.bus_class, cif.bus_mod};

	// Each attribute bit passes when masked or equal
	for (genvar i = 0; i < 8; i++)
	begin : g_bit
		assign bit_ok[i] = cif.attr[abm_pkg::MASK_LSB + i] | (cif.attr[i] == bus_attr[i]);
	end

	always_comb
	begin
		case (cif.addr_case)
			abm_pkg::CASE_EQUAL:   addr_ok = (cif.bus_addr == cif.low);
			abm_pkg::CASE_INSIDE:  addr_ok = (cif.bus_addr >= cif.low) && (cif.bus_addr <= cif.high);
			abm_pkg::CASE_OUTSIDE: addr_ok = (cif.bus_addr < cif.low) || (cif.bus_addr > cif.high);
			default:               addr_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.hit = cif.enable & cif.bus_valid & addr_ok & (&bit_ok);
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign cif.hit = st_r.hit;
endmodule

// ==== tb/local_bus_model.sv ====
// Purpose: Processor local bus model issuing one transfer at a time.
// Assumes: Caller enters just after a rising clock edge.
// Notes:   Idle fields carry inverted values.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module local_bus_model
(
	input  wire logic        clock,
	output logic             bus_valid,
	output logic      [31:0] bus_addr,
	output logic             bus_rd,
	output logic      [1:0]  bus_size,
	output logic      [1:0]  bus_class,
	output logic      [2:0]  bus_mod
);
	initial
	begin
		bus_valid = 1'b0;
		bus_addr  = 32'h0000_0000;
		{bus_rd, bus_size, bus_class, bus_mod} = 8'h00;
	end

	task automatic xfer(input logic [31:0] addr, input logic [7:0] attr);
		bus_valid = 1'b1;
		bus_addr  = addr;
		{bus_rd, bus_size, bus_class, bus_mod} = attr;
		@(posedge clock);
		#1;
		bus_valid = 1'b0;
		// Flipped so a compare that ignores valid cannot match stale data
		bus_addr  = ~addr;
		{bus_rd, bus_size, bus_class, bus_mod} = ~attr;
	endtask
endmodule

// ==== tb/address_breakpoint_match_test.sv ====
// Purpose: Self-checking bench of the address breakpoint comparator.
// Assumes: Inputs move 1 ns after each rising edge.
// Notes:   Every register task lets one extra edge pass before returning.
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

////////////////////////////////////////////////////////////////////////////////
module address_breakpoint_match_test;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic        cpu_wr = 1'b0, dbg_req = 1'b0, dbg_wr = 1'b0, dbg_mem_req = 1'b0;
	logic [4:0]  cpu_sel = 5'h00, dbg_sel = 5'h00;
	logic [31:0] cpu_wdata = 32'h0, dbg_wdata = 32'h0, dbg_mem_addr = 32'h0;
	logic        bp_enable = 1'b0;
	logic [1:0]  addr_case = 2'h0;
	logic [31:0] dbg_rdata, mem_cmd_addr, bus_addr;
	logic        dbg_rvalid, bus_valid, bus_rd, addr_trigger;
	logic [1:0]  mem_cmd_class, bus_size, bus_class;
	logic [2:0]  mem_cmd_mod, bus_mod;
	logic [15:0] debug_cfg;
	int          bad_count = 0;
	int          n_tests = 0;
	int          cycles = 0;

	always #2.5 clock = ~clock;

	local_bus_model i_local_bus_model (.clock(clock), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .bus_size(bus_size), .bus_class(bus_class), .bus_mod(bus_mod));

	address_breakpoint_match i_address_breakpoint_match (.clock(clock), .rst_n(rst_n),
		.cpu_wr(cpu_wr), .cpu_sel(cpu_sel), .cpu_wdata(cpu_wdata), .dbg_req(dbg_req),
		.dbg_wr(dbg_wr), .dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata),
		.dbg_rvalid(dbg_rvalid), .dbg_mem_req(dbg_mem_req), .dbg_mem_addr(dbg_mem_addr),
		.mem_cmd_addr(mem_cmd_addr), .mem_cmd_class(mem_cmd_class), .mem_cmd_mod(mem_cmd_mod),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_size(bus_size),
		.bus_class(bus_class), .bus_mod(bus_mod), .bp_enable(bp_enable), .addr_case(addr_case),
		.addr_trigger(addr_trigger), .debug_cfg(debug_cfg));

	////////////////////////////////////////////////////////////////////////////////
	task automatic step();
		@(posedge clock);
		#1;
	endtask

	task automatic cpu_write(input logic [4:0] sel, input logic [31:0] data);
		cpu_wr    = 1'b1;
		cpu_sel   = sel;
		cpu_wdata = data;
		step();
		cpu_wr = 1'b0;
		step();
	endtask

	task automatic dbg_write(input logic [4:0] sel, input logic [31:0] data);
		dbg_req   = 1'b1;
		dbg_wr    = 1'b1;
		dbg_sel   = sel;
		dbg_wdata = data;
		step();
		dbg_req = 1'b0;
		dbg_wr  = 1'b0;
		step();
	endtask

	task automatic dbg_read(input logic [4:0] sel, output logic [31:0] data);
		dbg_req = 1'b1;
		dbg_sel = sel;
		step();
		dbg_req = 1'b0;
		`CHK("read valid", 1'b1, dbg_rvalid)
		data = dbg_rdata;
		step();
	endtask

	task automatic read_chk(input logic [4:0] sel, input logic [31:0] exp, input string nm);
		logic [31:0] d;
		dbg_read(sel, d);
		`CHK(nm, exp, d)
	endtask

	task automatic bus_hit(input logic [31:0] addr, input logic [7:0] attr, input logic exp);
		i_local_bus_model.xfer(addr, attr);
		`CHK("trigger", exp, addr_trigger)
		step();
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		`CHK("cfg out", 16'h0000, debug_cfg)
		`CHK("cmd mod", 3'h5, mem_cmd_mod)
		`CHK("cmd class", 2'h0, mem_cmd_class)
		read_chk(abm_pkg::SEL_CONFIG, abm_pkg::CONFIG_RESET, "config");
		read_chk(abm_pkg::SEL_ATTRIBUTE, 32'h0000_0005, "attr");
		read_chk(abm_pkg::SEL_LOW_BOUND, 32'h0000_0000, "low");
		read_chk(abm_pkg::SEL_HIGH_BOUND, 32'h0000_0000, "high");
		read_chk(5'h01, 32'h0000_0000, "unmapped");
	endtask

	task automatic t_lock();
		cpu_write(abm_pkg::SEL_LOW_BOUND, 32'h0000_0ABC);
		read_chk(abm_pkg::SEL_LOW_BOUND, 32'h0000_0000, "locked low");
		dbg_write(abm_pkg::SEL_CONFIG, 32'h0000_0000);
		cpu_write(abm_pkg::SEL_CONFIG, 32'h0001_00A5);
		read_chk(abm_pkg::SEL_CONFIG, 32'h0000_00A5, "cpu config");
		`CHK("cfg out", 16'h00A5, debug_cfg)
		cpu_write(abm_pkg::SEL_LOW_BOUND, 32'h0000_0100);
		cpu_write(abm_pkg::SEL_HIGH_BOUND, 32'h0000_0200);
		read_chk(abm_pkg::SEL_LOW_BOUND, 32'h0000_0100, "low");
		read_chk(abm_pkg::SEL_HIGH_BOUND, 32'h0000_0200, "high");
	endtask

	// Boundary addresses around both bounds, every case select
	task automatic t_range();
		logic [31:0] a [5] = '{32'h0000_00FF, 32'h0000_0100, 32'h0000_0180, 32'h0000_0200, 32'h0000_0201};
		logic        inr;
		logic        exp;
		bp_enable = 1'b1;
		dbg_write(abm_pkg::SEL_ATTRIBUTE, 32'h0000_FF00);
		for (int c = 0; c < 4; c++)
			for (int i = 0; i < 5; i++)
			begin
				inr = (a[i] >= 32'h0000_0100) && (a[i] <= 32'h0000_0200);
				exp = (c == 0) ? (a[i] == 32'h0000_0100) : (c == 1) ? inr : (c == 2) ? !inr : 1'b0;
				addr_case = 2'(c);
				bus_hit(a[i], 8'hFF, exp);
			end
	endtask

	task automatic t_attr();
		logic [7:0] v = {1'b1, abm_pkg::WIDTH_WORD, abm_pkg::CLASS_NORMAL, abm_pkg::MOD_SUP_DATA};
		logic [7:0] w;
		addr_case = abm_pkg::CASE_EQUAL;
		for (int b = 0; b < 8; b++)
		begin
			dbg_write(abm_pkg::SEL_ATTRIBUTE, {24'h0, v});
			bus_hit(32'h0000_0100, v, 1'b1);
			bus_hit(32'h0000_0100, v ^ (8'h01 << b), 1'b0);
			dbg_write(abm_pkg::SEL_ATTRIBUTE, {16'h0, 8'(8'h01 << b), v});
			bus_hit(32'h0000_0100, v ^ (8'h01 << b), 1'b1);
		end
		for (int c = 0; c < 4; c++)
			for (int m = 0; m < 8; m++)
			begin
				w = {1'b0, abm_pkg::WIDTH_BYTE, 2'(c), 3'(m)};
				dbg_write(abm_pkg::SEL_ATTRIBUTE, {24'h0, w});
				`CHK("cmd class", 2'(c), mem_cmd_class)
				`CHK("cmd mod", 3'(m), mem_cmd_mod)
				bus_hit(32'h0000_0100, w, 1'b1);
			end
	endtask

	task automatic t_status();
		logic [31:0] d;
		bp_enable = 1'b0;
		dbg_write(abm_pkg::SEL_ATTRIBUTE, 32'h0000_FF00);
		bus_hit(32'h0000_0100, 8'h00, 1'b0);
		dbg_read(abm_pkg::SEL_CONFIG, d);
		`CHK("status idle", abm_pkg::ST_IDLE, d[31:28])
		bp_enable = 1'b1;
		dbg_write(abm_pkg::SEL_ATTRIBUTE, 32'h0000_FF00);
		dbg_read(abm_pkg::SEL_CONFIG, d);
		`CHK("status wait", abm_pkg::ST_WAITING, d[31:28])
		bus_hit(32'h0000_0100, 8'h00, 1'b1);
		dbg_read(abm_pkg::SEL_CONFIG, d);
		`CHK("status hit", abm_pkg::ST_TRIGGERED, d[31:28])
		`CHK("trig set", 1'b1, d[26])
		dbg_read(abm_pkg::SEL_CONFIG, d);
		`CHK("trig clear", 1'b0, d[26])
		// Hit and status read land on the same edge
		i_local_bus_model.xfer(32'h0000_0100, 8'h00);
		dbg_read(abm_pkg::SEL_CONFIG, d);
		`CHK("trig race", 1'b0, d[26])
		dbg_read(abm_pkg::SEL_CONFIG, d);
		`CHK("set wins", 1'b1, d[26])
		`CHK("status race", abm_pkg::ST_TRIGGERED, d[31:28])
	endtask

	task automatic t_mem();
		dbg_mem_addr = 32'hDEAD_0000;
		dbg_mem_req  = 1'b1;
		step();
		dbg_mem_req = 1'b0;
		`CHK("cmd addr", 32'hDEAD_0000, mem_cmd_addr)
		step();
		read_chk(abm_pkg::SEL_HIGH_BOUND, 32'hDEAD_0000, "high after cmd");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Full run is a few hundred cycles; the ceiling leaves wide margin
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			test_done();
		end
	end

	initial
	begin
		repeat (3) @(posedge clock);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_lock();
		t_range();
		t_attr();
		t_status();
		t_mem();
		test_done();
	end
endmodule
